// [hw/tx_serial_config_port.sv]
/*
 configuration register bank of the transmitter: decodes serial words,
 holds six configuration registers and the frequency word, drives
 transmit control and samples transmit data on the reference clock.
 assumes: all pins asynchronous to sys_clk; pll lock comes from the synthesizer.
*/
`timescale 1ns/1ns
module tx_serial_config_port
   import txcfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial port
   input wire logic serClk,
   input wire logic serData,
   input wire logic loadStrobe,
   // discrete control
   input wire logic chipActive,
   input wire logic tx_request_n,
   input wire logic pllLocked,
   // baseband data
   input wire logic ref_clock_in,
   input wire logic txDataIn,
   // outputs
   output logic tx_valid_out,
   output logic tx_valid_inv_out,
   output logic txEnable,
   output logic pllPowerDown,
   output logic calStart,
   output logic modData,
   output txcfg_pkg::cfg_t cfg,
   output logic [WORD_BITS-2:0] freqWord
);
   word_t word;
   logic [15:0] regs [REG_COUNT];
   logic [15:0] next_regs [REG_COUNT];
   logic [WORD_BITS-2:0] next_freqWord;
   logic resetSeen, next_resetSeen;
   localparam logic [15:0] DEFS [REG_COUNT] = '{DEF0, DEF1, DEF2, DEF3, DEF4, DEF5};
   localparam logic [15:0] MASKS [REG_COUNT] = '{MASK0, MASK1, MASK2, MASK3, MASK4, MASK5};

   serial_shifter shifter (
      .sysClk(sys_clk),
      .rst(rst),
      .serClk(serClk),
      .serData(serData),
      .loadStrobe(loadStrobe),
      .wordOut(word)
   );

   // word decode
   always_comb begin
      logic [4:0] addr;
      addr = word.word[ADDR_HI:ADDR_LO];
      next_regs = regs;
      next_freqWord = freqWord;
      next_resetSeen = 1'b0;
      if (word.valid) begin
         if (!word.word[TYPE_BIT]) begin
            next_freqWord = word.word[WORD_BITS-2:0];
         end else if (word.word[RESET_BIT]) begin
            next_regs = DEFS;
            next_resetSeen = 1'b1;
         end else if (word.word[PERMIT_BIT] && addr < 5'(REG_COUNT)) begin
            for (int i = 0; i < REG_COUNT; i++) begin
               if (addr == 5'(i)) begin
                  next_regs[i] = (word.word[15:0] & MASKS[i]) | (DEFS[i] & ~MASKS[i]);
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regs <= DEFS;
         freqWord <= '0;
         resetSeen <= 1'b0;
      end else begin
         regs <= next_regs;
         freqWord <= next_freqWord;
         resetSeen <= next_resetSeen;
      end
   end

   // field extraction
   cfg_t next_cfg;
   always_comb begin
      next_cfg.rate2048 = regs[0][RATE_BIT];
      next_cfg.askMode = regs[0][ASK_BIT];
      next_cfg.lowCurrent = regs[0][LOWCUR_BIT];
      next_cfg.pllSleep = regs[0][PLLSLEEP_BIT];
      next_cfg.singleCal = regs[0][SINGLECAL_BIT];
      next_cfg.lockGated = regs[0][LOCKGATE_BIT];
      next_cfg.divOffset = regs[1][DIVOFS_LO +: 4];
      next_cfg.filterEdge = regs[1][FEDGE_BIT];
      next_cfg.filterInvert = regs[1][FPOL_BIT];
      next_cfg.offDelay = regs[2][OFFDLY_LO +: 2];
      next_cfg.onDelay = regs[2][ONDLY_LO +: 6];
      next_cfg.modScale = regs[4][SCALE_LO +: 8];
      next_cfg.modOffset = regs[4][7:0];
   end

   // pin synchronisers
   logic [4:0] meta, sync;
   logic prevRef, prevCe;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta <= 5'h01;
         sync <= 5'h01;
         prevRef <= 1'b0;
         prevCe <= 1'b0;
      end else begin
         meta <= {txDataIn, ref_clock_in, pllLocked, chipActive, tx_request_n};
         sync <= meta;
         prevRef <= sync[3];
         prevCe <= sync[1];
      end
   end
   logic reqN, ceS, lockS, refS, dinS;
   assign reqN = sync[0];
   assign ceS = sync[1];
   assign lockS = sync[2];
   assign refS = sync[3];
   assign dinS = sync[4];

   // transmit sequencing
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ON_WAIT = 2'b01,
      ST_VALID = 2'b10,
      ST_OFF_WAIT = 2'b11
   } tx_state_t;
   tx_state_t state, next_state;
   logic [DLY_W-1:0] count, next_count;
   logic next_txValid, next_txEnable, next_pllPowerDown, next_calStart, next_modData;
   logic refEdge;

   always_comb begin
      logic gateOk;
      gateOk = !cfg.lockGated || lockS;
      refEdge = cfg.filterEdge ? (prevRef && !refS) : (!prevRef && refS);
      next_state = state;
      next_count = (count != '0) ? count - 1'b1 : count;
      next_txEnable = txEnable;
      case (state)
         ST_IDLE: begin
            next_txEnable = 1'b0;
            if (!reqN && ceS) begin
               next_state = ST_ON_WAIT;
               next_count = DLY_W'(ON_STEP_CYC * cfg.onDelay);
            end
         end
         ST_ON_WAIT: begin
            if (reqN) begin
               next_state = ST_IDLE;
            end else if (count == '0 && gateOk) begin
               next_state = ST_VALID;
               next_txEnable = 1'b1;
            end
         end
         ST_VALID: begin
            if (reqN || !gateOk || !ceS) begin
               next_state = ST_OFF_WAIT;
               next_count = DLY_W'(OFF_BASE_CYC + OFF_STEP_CYC * cfg.offDelay);
            end
         end
         ST_OFF_WAIT: begin
            if (count == '0) begin
               next_state = ST_IDLE;
               next_txEnable = 1'b0;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_txValid = (next_state == ST_VALID);
      next_pllPowerDown = cfg.pllSleep && reqN;
      next_calStart = cfg.singleCal ? resetSeen : (ceS && !prevCe && !reqN);
      next_modData = refEdge ? (dinS ^ cfg.filterInvert) : modData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         count <= '0;
         cfg <= '0;
         tx_valid_out <= 1'b0;
         tx_valid_inv_out <= 1'b1;
         txEnable <= 1'b0;
         pllPowerDown <= 1'b0;
         calStart <= 1'b0;
         modData <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         cfg <= next_cfg;
         tx_valid_out <= next_txValid;
         tx_valid_inv_out <= !next_txValid;
         txEnable <= next_txEnable;
         pllPowerDown <= next_pllPowerDown;
         calStart <= next_calStart;
         modData <= next_modData;
      end
   end
endmodule

// [hw/txcfg_pkg.sv]
/*
 holds field positions, reset values, timing constants and carrier types of the
 serial configuration port of the transmitter.
 assumes: the logic runs on a 250 MHz system clock.
*/
// Functional notes
// - sample transmit data on reference clock, no retiming
// - words are 24 bits, msb first
// - load addressed register on strobe rising edge
// - ignore data and clock while strobe high
// - shift data on serial clock rise, strobe low
// - bit 23 selects frequency or configuration word
// - reset restores six register defaults
// - rate bit selects 1024 or 2048 kbps
// - modulation bit selects ask or fsk
// - low current bit selects saving mode
// - single calibration bit chooses calibration trigger
// - lock gated bit blocks transmit while unlocked
// - filter edge bit picks reference clock edge
// - polarity bit inverts filter output
// - off delay is 3.5 us plus field times 40
// - on delay field sets request to on delay
// - scale and offset fields drive modulation coefficients
// - configuration write needs write permit bit
package txcfg_pkg;
   localparam int WORD_BITS = 24;
   localparam int TYPE_BIT = 23;
   localparam int RESET_BIT = 22;
   localparam int PERMIT_BIT = 21;
   localparam int ADDR_HI = 20;
   localparam int ADDR_LO = 16;
   localparam int REG_COUNT = 6;
   // register 0 fields
   localparam int RATE_BIT = 14;
   localparam int ASK_BIT = 13;
   localparam int LOWCUR_BIT = 12;
   localparam int PLLSLEEP_BIT = 11;
   localparam int SINGLECAL_BIT = 10;
   localparam int LOCKGATE_BIT = 9;
   // register 1 fields
   localparam int DIVOFS_LO = 12;
   localparam int FEDGE_BIT = 5;
   localparam int FPOL_BIT = 4;
   // register 2 fields
   localparam int OFFDLY_LO = 6;
   localparam int ONDLY_LO = 0;
   // register 4 fields
   localparam int SCALE_LO = 8;
   // defaults and writable masks
   localparam logic [15:0] DEF0 = 16'h263e;
   localparam logic [15:0] DEF1 = 16'h8487;
   localparam logic [15:0] DEF2 = 16'h158a;
   localparam logic [15:0] DEF3 = 16'h5505;
   localparam logic [15:0] DEF4 = 16'h0080;
   localparam logic [15:0] DEF5 = 16'h0000;
   localparam logic [15:0] MASK0 = 16'h7e00;
   localparam logic [15:0] MASK1 = 16'hf030;
   localparam logic [15:0] MASK2 = 16'h00ff;
   localparam logic [15:0] MASK3 = 16'h0000;
   localparam logic [15:0] MASK4 = 16'hffff;
   localparam logic [15:0] MASK5 = 16'h0000;
   // timing
   localparam int SYS_CLK_MHZ = 250;
   localparam int REF_CLK_KHZ = 12288;
   localparam int OFF_BASE_NS = 3500;
   localparam int OFF_STEP_REFS = 40;
   localparam int OFF_BASE_CYC = OFF_BASE_NS * SYS_CLK_MHZ / 1000;
   localparam int OFF_STEP_CYC = OFF_STEP_REFS * SYS_CLK_MHZ * 1000 / REF_CLK_KHZ;
   localparam int ON_STEP_CYC = 8 * SYS_CLK_MHZ * 1000 / REF_CLK_KHZ;
   localparam int DLY_W = 14;

   typedef struct packed {
      logic rate2048;
      logic askMode;
      logic lowCurrent;
      logic pllSleep;
      logic singleCal;
      logic lockGated;
      logic [3:0] divOffset;
      logic filterEdge;
      logic filterInvert;
      logic [1:0] offDelay;
      logic [5:0] onDelay;
      logic [7:0] modScale;
      logic [7:0] modOffset;
   } cfg_t;

   typedef struct packed {
      logic valid;
      logic [WORD_BITS-1:0] word;
   } word_t;
endpackage

// [hw/serial_shifter.sv]
/*
 serial shifter: samples the three serial pins, shifts a word on clock
 rises while the strobe is low and emits it on the strobe rise.
 assumes: pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module serial_shifter
   import txcfg_pkg::*;
(
   // clock and reset
   input wire logic sysClk,
   input wire logic rst,
   // pins
   input wire logic serClk,
   input wire logic serData,
   input wire logic loadStrobe,
   // word out
   output txcfg_pkg::word_t wordOut
);
   logic [2:0] meta;
   logic [2:0] sync;
   logic prevClk, prevStb;
   logic [WORD_BITS-1:0] shift, next_shift;
   word_t next_wordOut;

   always_comb begin
      next_shift = shift;
      next_wordOut.valid = 1'b0;
      next_wordOut.word = wordOut.word;
      if (!sync[2] && sync[0] && !prevClk) begin
         next_shift = {shift[WORD_BITS-2:0], sync[1]};
      end
      if (sync[2] && !prevStb) begin
         next_wordOut.valid = 1'b1;
         next_wordOut.word = shift;
      end
   end

   always_ff @(posedge sysClk) begin
      if (rst) begin
         // strobe idles high so release of reset makes no false load edge
         meta <= 3'h4;
         sync <= 3'h4;
         prevClk <= 1'b0;
         prevStb <= 1'b1;
         shift <= '0;
         wordOut <= '0;
      end else begin
         meta <= {loadStrobe, serData, serClk};
         sync <= meta;
         prevClk <= sync[0];
         prevStb <= sync[2];
         shift <= next_shift;
         wordOut <= next_wordOut;
      end
   end
endmodule

// [bench/serial_ctrl_model.sv]
/* controller model: shifts 24-bit words msb first, then strobes; assumes the bench clock. */
`timescale 1ns/1ns
module serial_ctrl_model (
   // clock
   input wire logic sysClk,
   // serial pins
   output logic serClk,
   output logic serData,
   output logic loadStrobe
);
   initial {serClk, serData, loadStrobe} = 3'h1;
   task automatic send(input logic [23:0] w);
      loadStrobe <= 0;
      for (int i = 23; i >= 0; i--) begin
         serData <= w[i];
         repeat (4) @(posedge sysClk);
         serClk <= 1;
         repeat (4) @(posedge sysClk);
         serClk <= 0;
      end
      repeat (4) @(posedge sysClk);
      loadStrobe <= 1;
      // released data line flips each cycle
      repeat (500) begin
         serData <= ~serData;
         @(posedge sysClk);
      end
   endtask
endmodule

// [bench/txcfg_monitor.sv]
/* checker on the port pins; assumes it is bound into tx_serial_config_port. */
`timescale 1ns/1ns
module txcfg_monitor
   import txcfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // inputs
   input wire logic loadStrobe,
   input wire logic tx_request_n,
   input wire logic pllLocked,
   // outputs
   input wire logic tx_valid_out,
   input wire logic tx_valid_inv_out,
   input wire logic txEnable,
   input wire logic pllPowerDown,
   input wire logic calStart,
   input wire txcfg_pkg::cfg_t cfg,
   input wire logic [WORD_BITS-2:0] freqWord
);
   logic [13:0] offCnt, onCnt, next_offCnt, next_onCnt;
   int offLen;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   assign offLen = OFF_BASE_CYC + cfg.offDelay * OFF_STEP_CYC;
   // cycles since valid fell, and since request went low
   always_comb begin
      next_offCnt = tx_valid_out ? 14'h0000 : offCnt + 14'(txEnable);
      next_onCnt = (tx_request_n || tx_valid_out) ? 14'h0000 : onCnt + 14'h0001;
   end
   always_ff @(posedge sys_clk) begin
      offCnt <= rst ? 14'h0000 : next_offCnt;
      onCnt <= rst ? 14'h0000 : next_onCnt;
   end
   sequence txWentOff;
      $fell(txEnable);
   endsequence
   chk_valid_pair: assert property (tx_valid_inv_out == !tx_valid_out)
      else $error("valid pair not complementary");
   chk_lock_gate: assert property ((cfg.lockGated && !pllLocked) [*6] |-> !$rose(tx_valid_out))
      else $error("valid rose while unlocked");
   chk_on_delay: assert property ($rose(tx_valid_out) |-> onCnt >= cfg.onDelay * 160)
      else $error("transmitter on too early");
   chk_off_delay: assert property (txWentOff |-> offCnt inside {[offLen - 1:offLen + 1]})
      else $error("off delay wrong");
   chk_sleep_on: assert property ((cfg.pllSleep && tx_request_n) [*5] |-> pllPowerDown)
      else $error("pll not powered down");
   chk_sleep_off: assert property ((!cfg.pllSleep || !tx_request_n) [*5] |-> !pllPowerDown)
      else $error("pll powered down");
   chk_cal_pulse: assert property (calStart |=> !calStart)
      else $error("calibration pulse too long");
   chk_load_time: assert property ($changed(freqWord) |->
      loadStrobe && $past(loadStrobe, 4) && !$past(loadStrobe, 8))
      else $error("frequency word changed off load");
   chk_reset_vals: assert property ($fell(rst) |-> ##1 freqWord == '0 && cfg.askMode
      && cfg.modOffset == DEF4[7:0])
      else $error("reset values wrong");
endmodule
bind tx_serial_config_port txcfg_monitor txcfg_monitor_i (.sys_clk, .rst, .loadStrobe,
   .tx_request_n, .pllLocked, .tx_valid_out, .tx_valid_inv_out, .txEnable, .pllPowerDown,
   .calStart, .cfg, .freqWord);

// [bench/test_tx_serial_config_port.sv]
/* testbench of the configuration port; assumes serial_ctrl_model on the serial pins. */
`timescale 1ns/1ns
module test_tx_serial_config_port;
   import txcfg_pkg::*;
   localparam logic [15:0] DEFS [6] = '{DEF0, DEF1, DEF2, DEF3, DEF4, DEF5};
   localparam logic [15:0] MASKS [6] = '{MASK0, MASK1, MASK2, MASK3, MASK4, MASK5};
   logic sys_clk, rst, serClk, serData, loadStrobe, chipActive, tx_request_n, pllLocked;
   logic ref_clock_in, txDataIn, tx_valid_out, tx_valid_inv_out, txEnable, pllPowerDown;
   logic calStart, modData, lastValid, lastStrobe;
   cfg_t cfg;
   logic [WORD_BITS-2:0] freqWord, ef;
   logic [15:0] er [6];
   logic [61:0] notes [$];
   int failCount, comparisons, cycles, loadAge, seed;
   tx_serial_config_port tx_serial_config_port_i (.*);
   serial_ctrl_model serial_ctrl_model_i (.sysClk(sys_clk), .serClk, .serData, .loadStrobe);
   initial begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end
   function automatic logic [61:0] note(input logic v, e, d);
      return {v, e, d ^ er[1][FPOL_BIT], er[0][RATE_BIT-:6], er[1][DIVOFS_LO+:4],
         er[1][FEDGE_BIT-:2], er[2][OFFDLY_LO+:2], er[2][ONDLY_LO+:6], er[4], ef};
   endfunction
   task automatic check(input string what, input logic [61:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic testDone;
      if (notes.size() != 0) failCount++;
      if (failCount == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic put(input logic [23:0] w);
      logic [4:0] a;
      logic d;
      a = w[20:16];
      d = 1'($random(seed));
      if (!w[23]) ef = w[22:0];
      else if (w[22]) er = DEFS;
      else if (w[21] && a < 6) er[a] = er[a] & ~MASKS[a] | w[15:0] & MASKS[a];
      txDataIn <= d;
      notes.push_back(note(0, 0, d));
      serial_ctrl_model_i.send(w);
   endtask
   // oldest note against outputs when a load lands or valid moves
   always @(posedge sys_clk) begin
      lastValid <= tx_valid_out;
      lastStrobe <= loadStrobe;
      loadAge <= (loadStrobe && !lastStrobe) ? 0 : loadAge + 1;
      if (!rst && (loadAge == 40 || tx_valid_out !== lastValid))
         check("outputs", {tx_valid_out, txEnable, modData, cfg, freqWord}, notes.pop_front());
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles % 10 == 0) ref_clock_in <= ~ref_clock_in;
      if (cycles == 30000) begin
         failCount++;
         testDone;
      end
   end
   initial begin
      seed = 32'h0000_6a7c;
      {rst, chipActive, tx_request_n, pllLocked, txDataIn, ref_clock_in} = 6'h28;
      {lastValid, lastStrobe, ef, loadAge} = {2'h1, 23'h00_0000, 32'h0000_0064};
      er = DEFS;
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      put(24'hc0_0000);
      for (int i = 0; i < 16; i++)
         put({i % 4 != 0, 1'b0, i % 3 != 0, 5'((i + 7) % 8), 16'($random(seed))});
      put(24'ha2_0045);
      put(24'ha0_0a00);
      chipActive <= 1;
      tx_request_n <= 0;
      notes.push_back(note(1, 1, txDataIn));
      repeat (4000) @(posedge sys_clk);
      pllLocked <= 1;
      for (int n = 0; n < 500 && tx_valid_out !== 1'b1; n++) @(posedge sys_clk);
      tx_request_n <= 1;
      notes.push_back(note(0, 1, txDataIn));
      repeat (2000) @(posedge sys_clk);
      testDone;
   end
endmodule
